// *** dv/demr_asserts.sv ***
`timescale 1ns/1ps
module demr_asserts #(
  parameter bit WIDE_ORG = 1'b0
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [2:0]  ba,
  input wire logic [14:0] addr
);
  import demr_pkg::*;
  logic [3:0] cmd;
  logic       mrs;
  logic       pre_all;
  logic       nop;
  // decoded link commands, only writes to the first extended register count
  assign cmd     = {cs_n, ras_n, cas_n, we_n};
  assign mrs     = cmd == CMD_MRS && ba == BA_EXT_ONE;
  assign pre_all = cmd == CMD_PRE && addr[PRE_ALL_BIT];
  assign nop     = cmd == CMD_NOP;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_cal_default;
    mrs && addr[CAL_HI:CAL_LO] == CAL_DEFAULT;
  endsequence
  sequence s_cal_exit;
    mrs && addr[CAL_HI:CAL_LO] == CAL_EXIT;
  endsequence
  // init word must arrive soon after reset and keep the loop on
  sequence s_init_write;
    ##[1:12] (mrs && !addr[DLL_BIT]);
  endsequence
  mrs_upper_zero_a : assert property (mrs |-> addr[14:13] == 2'h0)
    else $error("config write with upper address bits set");
  mrs_cke_high_a : assert property (mrs |-> cke && $past(cke))
    else $error("config write without clock enable held high");
  mrs_gap_a : assert property (mrs |=> nop)
    else $error("command issued inside the config write gap");
  init_write_a : assert property ($fell(reset) |-> s_init_write)
    else $error("no loop-on config write after reset");
  // a calibration exit write may follow its default write without a precharge
  mrs_precharged_a : assert property (mrs |-> $past(pre_all, 3) || $past(mrs, 2)
    || $past(mrs, 3) || $past(mrs, 4))
    else $error("config write not preceded by precharge all");
  sr_entry_a : assert property ($fell(cke) |-> cmd == CMD_REF)
    else $error("clock enable dropped without self refresh entry");
  cal_exit_a : assert property (s_cal_default |-> ##[1:4] s_cal_exit)
    else $error("calibration default not followed by exit write");
  wide_read_strobe_enable_a : assert property (mrs |-> !(WIDE_ORG && addr[READ_STROBE_ENABLE_BIT]))
    else $error("read strobe enable written on wide organization");
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
  import demr_pkg::*;
  logic             clk = 1'b0;
  logic             reset = 1'b1;
  logic             cfg_req = 1'b0;
  logic             sr_req = 1'b0;
  logic [CFG_W-1:0] cfg_word = '0;
  logic             cfg_ready_q, in_sr_q, rd_ok_q, cfg_valid_q, cfg_reject_q;
  logic             self_refresh_q, dll_on_q, dll_locked_q, drive_reduced_q;
  logic             al_reserved_q, strobe_comp_off_q, read_strobe_enable_q;
  logic             cal_default_q, out_buf_off_q;
  logic [2:0]       add_latency_q, driver_calibration_program_q;
  logic [7:0]       rtt_ohm_q;
  logic [CFG_W-1:0] cfg_word_q;
  logic [CFG_W-1:0] cur_word_q;
  int               n_mismatch = 0;
  int               n_compared = 0;
  integer           seed = 44;
  int               exp_q[$];
  int               ohm[4] = '{0, 75, 150, 50};
  // 200 MHz clock
  always #2.5 clk = ~clk;
  demr_if demr_if_i ();
  // wide organization so the read strobe bit must be forced to zero
  demr_ctrl #(.WIDE_ORG(1'b1)) demr_ctrl_i (.clk(clk), .reset(reset), .pins(demr_if_i),
    .cfg_req(cfg_req), .cfg_word(cfg_word), .sr_req(sr_req), .cfg_ready_q(cfg_ready_q),
    .in_sr_q(in_sr_q), .rd_ok_q(rd_ok_q), .cur_word_q(cur_word_q));
  demr_device demr_device_i (.clk(clk), .reset(reset), .pins(demr_if_i),
    .cfg_valid_q(cfg_valid_q), .cfg_reject_q(cfg_reject_q), .cfg_word_q(cfg_word_q),
    .self_refresh_q(self_refresh_q), .dll_on_q(dll_on_q), .dll_locked_q(dll_locked_q),
    .drive_reduced_q(drive_reduced_q), .add_latency_q(add_latency_q),
    .al_reserved_q(al_reserved_q), .rtt_ohm_q(rtt_ohm_q),
    .strobe_comp_off_q(strobe_comp_off_q), .read_strobe_enable_q(read_strobe_enable_q),
    .driver_calibration_program_q(driver_calibration_program_q),
    .cal_default_q(cal_default_q), .out_buf_off_q(out_buf_off_q));
  demr_asserts #(.WIDE_ORG(1'b1)) demr_asserts_i (.clk(clk), .reset(reset),
    .cke(demr_if_i.cke), .cs_n(demr_if_i.cs_n), .ras_n(demr_if_i.ras_n),
    .cas_n(demr_if_i.cas_n), .we_n(demr_if_i.we_n), .ba(demr_if_i.ba), .addr(demr_if_i.addr));

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // bounded wait, a hung controller shows up as a mismatch
  task automatic wait_ready();
    int k;
    k = 0;
    while (cfg_ready_q !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    chk("cfg_ready_q", 1, cfg_ready_q);
  endtask

  // reference decode of the last word that should sit in the device
  task automatic check_fields();
    int w;
    int al;
    w = exp_q.pop_front();
    al = (w >> 3) & 7;
    chk("cfg_word_q", w, cfg_word_q);
    chk("cur_word_q", w, cur_word_q);
    chk("cal_default_q", ((w >> 7) & 7) == 7, cal_default_q);
    chk("cfg_valid_q", 1, cfg_valid_q);
    chk("dll_on_q", !(w & 1), dll_on_q);
    chk("drive_reduced_q", (w >> 1) & 1, drive_reduced_q);
    chk("add_latency_q", al > 5 ? 0 : al, add_latency_q);
    chk("al_reserved_q", al > 5, al_reserved_q);
    chk("rtt_ohm_q", ohm[((w >> 5) & 2) | ((w >> 2) & 1)], rtt_ohm_q);
    chk("strobe_comp_off_q", (w >> 10) & 1, strobe_comp_off_q);
    chk("read_strobe_enable_q", (w >> 11) & 1, read_strobe_enable_q);
    chk("cal_program", (w >> 7) & 7, driver_calibration_program_q);
    chk("out_buf_off_q", (w >> 12) & 1, out_buf_off_q);
  endtask

  // the device ends with A11 cleared and a default calibration already exited
  task automatic write_word(input logic [CFG_W-1:0] w);
    int e;
    e = int'(w) & ~(1 << 11);
    if (((e >> 7) & 7) == 7) e = e & ~(7 << 7);
    wait_ready();
    cfg_req = 1'b1;
    cfg_word = w;
    @(negedge clk);
    cfg_req = 1'b0;
    exp_q.push_back(e);
    @(negedge clk);
    if (((w >> 7) & 7) == 7) begin
      // default calibration stands only until the exit write lands
      repeat (4) @(negedge clk);
      chk("cal_default_q", 1, cal_default_q);
    end
    wait_ready();
    check_fields();
  endtask

  // only an open bank or a write during self refresh could make the device refuse a write here
  always @(negedge clk) begin
    if (!reset && cfg_reject_q !== 1'b0) chk("cfg_reject_q", 0, cfg_reject_q);
  end

  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    exp_q.push_back(0);
    wait_ready();
    check_fields();
    // every latency code, every termination code, calibration default last
    for (int i = 0; i < 8; i++) begin
      write_word(13'((i << 3) | ((i & 2) << 5) | ((i & 1) << 2) | (i == 7 ? 7 << 7 : 0)));
    end
    for (int i = 0; i < 12; i++) write_word(13'($random(seed)));
    write_word(13'h0001);
    repeat (DLL_LOCK_CYC + 10) @(negedge clk);
    chk("rd_ok_q", 0, rd_ok_q);
    write_word(13'h0000);
    chk("rd_ok_q", 0, rd_ok_q);
    repeat (DLL_LOCK_CYC + 10) @(negedge clk);
    chk("rd_ok_q", 1, rd_ok_q);
    chk("dll_locked_q", 1, dll_locked_q);
    sr_req = 1'b1;
    repeat (4) @(negedge clk);
    chk("in_sr_q", 1, in_sr_q);
    chk("self_refresh_q", 1, self_refresh_q);
    chk("dll_on_q", 0, dll_on_q);
    chk("cke", 0, demr_if_i.cke);
    // a request during self refresh must not reach the register
    cfg_req = 1'b1;
    cfg_word = 13'h0aaa;
    repeat (3) @(negedge clk);
    cfg_req = 1'b0;
    chk("cfg_word_q", 0, cfg_word_q);
    @(negedge clk);
    sr_req = 1'b0;
    @(negedge clk);
    chk("rd_ok_q", 0, rd_ok_q);
    repeat (3) @(negedge clk);
    chk("self_refresh_q", 0, self_refresh_q);
    chk("dll_on_q", 1, dll_on_q);
    chk("rd_ok_q", 0, rd_ok_q);
    wait_ready();
    close_out();
  end
endmodule

// *** src/demr_ctrl.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - all strobes low, bank 001, loads register
// - precharge all banks, clock enable high first
// - wait write gap before next command
// - write register during initialization
// - rewrite only while all banks precharged
// - enable loop for normal operation
// - device stops loop in self refresh
// - 200 cycles after loop enable before reads
// - A1 selects full or reduced drive
// - wide organization writes read strobe zero
// - after calibration default, write calibration exit
module demr_ctrl #(
  parameter bit WIDE_ORG = 1'b0
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  demr_if.ctrl                           pins,
  input  wire logic                      cfg_req,
  input  wire logic [demr_pkg::CFG_W-1:0] cfg_word,
  input  wire logic                      sr_req,
  output logic                           cfg_ready_q,
  output logic                           in_sr_q,
  output logic                           rd_ok_q,
  output logic [demr_pkg::CFG_W-1:0]     cur_word_q
);
  import demr_pkg::*;

  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_PRE  = 3'h1,
    ST_MRS  = 3'h3,
    ST_GAP  = 3'h2,
    ST_IDLE = 3'h6,
    ST_SR   = 3'h7
  } demr_state_t;

  demr_state_t      state_q;
  demr_state_t      state_d;
  logic [CNT_W-1:0] wait_q;
  logic [CNT_W-1:0] wait_d;
  logic [CNT_W-1:0] lock_q;
  logic [CFG_W-1:0] pend_q;
  logic [CFG_W-1:0] masked;
  logic [3:0]       cmd_d;
  logic             cke_d;
  logic [2:0]       ba_d;
  logic [14:0]      addr_d;
  logic             issue_cfg;
  logic             sr_leave;

  // the narrow strobe option does not exist on the wide part
  always_comb begin
    masked = cfg_word;
    if (WIDE_ORG) begin
      masked[READ_STROBE_ENABLE_BIT] = 1'b0;
    end
  end

  // sequencing and the pin values for the next cycle
  always_comb begin
    state_d   = state_q;
    wait_d    = (wait_q != '0) ? wait_q - 1'b1 : wait_q;
    cmd_d     = CMD_NOP;
    cke_d     = 1'b1;
    ba_d      = 3'h0;
    addr_d    = 15'h0000;
    issue_cfg = 1'b0;
    sr_leave  = 1'b0;
    case (state_q)
      ST_INIT: begin
        // clock enable is raised first; the first command follows a cycle later
        state_d = ST_PRE;
      end
      ST_PRE: begin
        cmd_d               = CMD_PRE;
        addr_d[PRE_ALL_BIT] = 1'b1;
        wait_d              = CNT_W'(PRE_WAIT_CYC - 1);
        state_d             = ST_MRS;
      end
      ST_MRS: begin
        if (wait_q == '0) begin
          cmd_d     = CMD_MRS;
          ba_d      = BA_EXT_ONE;
          addr_d    = {2'b00, pend_q};
          issue_cfg = 1'b1;
          wait_d    = CNT_W'(GAP_CYC - 1);
          state_d   = ST_GAP;
        end
      end
      ST_GAP: begin
        // nothing else goes out until the write gap is over
        if (wait_q == '0) begin
          if (cur_word_q[CAL_HI:CAL_LO] == CAL_DEFAULT) begin
            state_d = ST_MRS;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (sr_req) begin
          cmd_d   = CMD_REF;
          cke_d   = 1'b0;
          state_d = ST_SR;
        end else if (cfg_req) begin
          state_d = ST_PRE;
        end
      end
      ST_SR: begin
        cke_d = 1'b0;
        if (!sr_req) begin
          cke_d    = 1'b1;
          sr_leave = 1'b1;
          state_d  = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_INIT;
      wait_q  <= '0;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
    end
  end

  // registered pins so the memory sees clean edges
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pins.cke   <= 1'b0;
      pins.cs_n  <= 1'b1;
      pins.ras_n <= 1'b1;
      pins.cas_n <= 1'b1;
      pins.we_n  <= 1'b1;
      pins.ba    <= 3'h0;
      pins.addr  <= 15'h0000;
    end else begin
      pins.cke   <= cke_d;
      pins.cs_n  <= cmd_d[3];
      pins.ras_n <= cmd_d[2];
      pins.cas_n <= cmd_d[1];
      pins.we_n  <= cmd_d[0];
      pins.ba    <= ba_d;
      pins.addr  <= addr_d;
    end
  end

  // word to write next; init word keeps the loop on
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_q     <= INIT_WORD;
      cur_word_q <= '0;
    end else begin
      if (state_q == ST_IDLE && !sr_req && cfg_req) begin
        pend_q <= masked;
      end else if (issue_cfg && pend_q[CAL_HI:CAL_LO] == CAL_DEFAULT) begin
        pend_q[CAL_HI:CAL_LO] <= CAL_EXIT;
      end
      if (issue_cfg) begin
        cur_word_q <= pend_q;
      end
    end
  end

  // lock wait restarts on every write with the loop on and on self refresh exit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_q <= CNT_W'(DLL_LOCK_CYC);
    end else if ((issue_cfg && !pend_q[DLL_BIT]) || sr_leave) begin
      lock_q <= CNT_W'(DLL_LOCK_CYC);
    end else if (lock_q != '0) begin
      lock_q <= lock_q - 1'b1;
    end
  end

  // reads only with the loop on and locked; a disabled loop is abnormal use
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_ok_q     <= 1'b0;
      cfg_ready_q <= 1'b0;
      in_sr_q     <= 1'b0;
    end else begin
      // the lock wait restarts on leaving self refresh, so that edge is not ready yet
      rd_ok_q     <= state_d == ST_IDLE && lock_q <= CNT_W'(1) && !sr_leave
                     && !cur_word_q[DLL_BIT];
      cfg_ready_q <= state_d == ST_IDLE;
      in_sr_q     <= state_d == ST_SR;
    end
  end
endmodule

// *** src/demr_device.sv ***
`timescale 1ns/1ps
module demr_device (
  input  wire logic                      clk,
  input  wire logic                      reset,
  demr_if.dev                            pins,
  output logic                           cfg_valid_q,
  output logic                           cfg_reject_q,
  output logic [demr_pkg::CFG_W-1:0]     cfg_word_q,
  output logic                           self_refresh_q,
  output logic                           dll_on_q,
  output logic                           dll_locked_q,
  output logic                           drive_reduced_q,
  output logic [2:0]                     add_latency_q,
  output logic                           al_reserved_q,
  output logic [7:0]                     rtt_ohm_q,
  output logic                           strobe_comp_off_q,
  output logic                           read_strobe_enable_q,
  output logic [2:0]                     driver_calibration_program_q,
  output logic                           cal_default_q,
  output logic                           out_buf_off_q
);
  import demr_pkg::*;

  logic [3:0]       cmd;
  logic             cke_prev_q;
  logic [7:0]       open_banks_q;
  logic             is_cfg_write;
  logic             accept;
  logic             sr_enter;
  logic             sr_exit;
  logic             dll_on_d;
  logic [CNT_W-1:0] lock_cnt_q;
  logic [CFG_W-1:0] w;

  // command decode, writes only with clock enable high in both cycles; self refresh entry and exit on a clock enable edge
  assign cmd          = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  assign is_cfg_write = cke_prev_q && pins.cke && cmd == CMD_MRS && pins.ba == BA_EXT_ONE;
  assign accept       = is_cfg_write && open_banks_q == 8'h00 && !self_refresh_q;
  assign sr_enter     = cke_prev_q && !pins.cke && cmd == CMD_REF;
  assign sr_exit      = self_refresh_q && !cke_prev_q && pins.cke;
  assign w            = pins.addr[CFG_W-1:0];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cke_prev_q <= 1'b0;
    end else begin
      cke_prev_q <= pins.cke;
    end
  end

  // bank state tracking: a write is refused while any row is open
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      open_banks_q <= 8'h00;
    end else if (cke_prev_q && pins.cke && cmd == CMD_ACT) begin
      open_banks_q[pins.ba] <= 1'b1;
    end else if (cke_prev_q && pins.cke && cmd == CMD_PRE) begin
      if (pins.addr[PRE_ALL_BIT]) begin
        open_banks_q <= 8'h00;
      end else begin
        open_banks_q[pins.ba] <= 1'b0;
      end
    end
  end

  // self refresh tracking
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      self_refresh_q <= 1'b0;
    end else if (sr_enter) begin
      self_refresh_q <= 1'b1;
    end else if (sr_exit) begin
      self_refresh_q <= 1'b0;
    end
  end

  // register load; contents mean nothing until the first accepted write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_valid_q  <= 1'b0;
      cfg_reject_q <= 1'b0;
      cfg_word_q   <= '0;
    end else begin
      cfg_reject_q <= is_cfg_write && !accept;
      if (accept) begin
        cfg_valid_q <= 1'b1;
        cfg_word_q  <= w;
      end
    end
  end

  // field decode, taken straight from the address lines on an accepted write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      drive_reduced_q              <= 1'b0;
      add_latency_q                <= 3'h0;
      al_reserved_q                <= 1'b0;
      rtt_ohm_q                    <= OHM_OFF;
      strobe_comp_off_q            <= 1'b0;
      read_strobe_enable_q         <= 1'b0;
      driver_calibration_program_q <= 3'h0;
      cal_default_q                <= 1'b0;
      out_buf_off_q                <= 1'b0;
    end else if (accept) begin
      drive_reduced_q   <= w[DIC_BIT];
      out_buf_off_q     <= w[QOFF_BIT];
      read_strobe_enable_q <= w[READ_STROBE_ENABLE_BIT];
      strobe_comp_off_q <= w[DQSN_BIT];
      driver_calibration_program_q <= w[CAL_HI:CAL_LO];
      cal_default_q     <= w[CAL_HI:CAL_LO] == CAL_DEFAULT;
      // reserved latency codes keep a latency of zero and raise a flag
      add_latency_q     <= (w[AL_HI:AL_LO] > AL_MAX) ? 3'h0 : w[AL_HI:AL_LO];
      al_reserved_q     <= w[AL_HI:AL_LO] > AL_MAX;
      case ({w[RTT_HI], w[RTT_LO]})
        RTT_OFF: rtt_ohm_q <= OHM_OFF;
        RTT_75:  rtt_ohm_q <= OHM_75;
        RTT_150: rtt_ohm_q <= OHM_150;
        default: rtt_ohm_q <= OHM_50;
      endcase
    end
  end

  // loop runs when enabled by the register and not in self refresh
  assign dll_on_d = cfg_valid_q && !cfg_word_q[DLL_BIT] && !self_refresh_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dll_on_q <= 1'b0;
    end else begin
      dll_on_q <= dll_on_d;
    end
  end

  // lock model: locked after the lock time of uninterrupted running
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_cnt_q   <= '0;
      dll_locked_q <= 1'b0;
    end else if (!dll_on_q) begin
      lock_cnt_q   <= '0;
      dll_locked_q <= 1'b0;
    end else if (lock_cnt_q != CNT_W'(DLL_LOCK_CYC - 1)) begin
      lock_cnt_q   <= lock_cnt_q + 1'b1;
    end else begin
      dll_locked_q <= 1'b1;
    end
  end
endmodule

// *** src/demr_if.sv ***
`timescale 1ns/1ps
// command and address pins from controller to memory, same clock on both ends
interface demr_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [2:0]  ba;
  logic [14:0] addr;
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr);
  modport dev  (input cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface

// *** src/demr_pkg.sv ***
package demr_pkg;
  // command codes on {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [2:0] BA_EXT_ONE = 3'h1;
  localparam int PRE_ALL_BIT = 10;
  // field positions of ext_config_reg_one
  localparam int CFG_W     = 13;
  localparam int QOFF_BIT  = 12;
  localparam int READ_STROBE_ENABLE_BIT  = 11;
  localparam int DQSN_BIT  = 10;
  localparam int CAL_HI    = 9;
  localparam int CAL_LO    = 7;
  localparam int RTT_HI    = 6;
  localparam int AL_HI     = 5;
  localparam int AL_LO     = 3;
  localparam int RTT_LO    = 2;
  localparam int DIC_BIT   = 1;
  localparam int DLL_BIT   = 0;
  localparam logic [2:0] CAL_EXIT    = 3'h0;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;
  localparam logic [2:0] AL_MAX      = 3'h5;
  // termination codes {A6, A2} and their values in ohm
  localparam logic [1:0] RTT_OFF = 2'h0;
  localparam logic [1:0] RTT_75  = 2'h1;
  localparam logic [1:0] RTT_150 = 2'h2;
  localparam logic [7:0] OHM_75  = 8'h4b;
  localparam logic [7:0] OHM_150 = 8'h96;
  localparam logic [7:0] OHM_50  = 8'h32;
  localparam logic [7:0] OHM_OFF = 8'h00;
  // word written during initialization: loop on, full drive, no latency
  localparam logic [CFG_W-1:0] INIT_WORD = 13'h0000;
  // timing
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int PRE_WAIT_NS    = 15;
  localparam int PRE_WAIT_CYC   = (PRE_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GAP_CYC        = 2;
  localparam int DLL_LOCK_CYC   = 200;
  localparam int CNT_W          = 8;
endpackage
